// *** core/wdt_pkg.sv ***
/*
 * Constants, register map and state types of the watchdog reset timer.
 * Assumes an 8-bit register port with a 16-bit address, one base clock.
 */
// Behaviour
// - the four inhibit bits always read one and are never stored.
// - counter write enable changes only when the write has bit 7 zero.
// - counter writes need counter write enable one; reads always allowed.
// - register write enable changes only when the write has bit 5 zero.
// - enable and flag writes need register write enable already one.
// - enable set by zero inhibit and one; cleared by both zero, or reset.
// - counter advances on selected clock only while enabled.
// - overflow with internal reset sets the overflow reset flag.
// - flag cleared by pin or guarded zero write; kept over internal reset.
// - counter is eight-bit up-counter, zero after reset.
// - tick at maximum overflows; internal reset one base cycle later.
// - internal reset lasts 512 oscillator cycles, resets chip except flag and interrupt status.
// - port mode bit 5 selects clock divided 8192 or watch divided 32.
// - written counter value continues counting; period 1 to 256 ticks.
// - clock stop bit 2 zero puts watchdog in standby; resets to one.
// - standby zero written while enabled is kept but waits for disable.
// - halts stop counter and keep registers; subactive needs watch clock.
package wdt_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_CTRL_STATUS = 16'hffb2;
	localparam logic [15:0] ADDR_COUNTER = 16'hffb3;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hffb4;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hffb5;
	localparam logic [15:0] ADDR_PORT_MODE_THREE = 16'hffca;
	localparam logic [15:0] ADDR_CLOCK_STOP_TWO = 16'hfffb;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_COUNTER_WE_INHIBIT = 7;
	localparam int BIT_COUNTER_WRITE_ENABLE = 6;
	localparam int BIT_REGWE_INHIBIT = 5;
	localparam int BIT_REGISTER_WRITE_ENABLE = 4;
	localparam int BIT_ENABLE_INHIBIT = 3;
	localparam int BIT_WATCHDOG_ENABLE = 2;
	localparam int BIT_FLAG_INHIBIT = 1;
	localparam int BIT_OVERFLOW_RESET_FLAG = 0;
	localparam int BIT_WATCHDOG_CLOCK_SELECT = 5;
	localparam int BIT_WATCHDOG_MODULE_STANDBY = 2;
	localparam int BIT_IRQ_OVERFLOW = 0;
	localparam int BIT_IRQ_RESET_DONE = 1;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RESET_COUNTER = 8'h00;
	localparam logic [7:0] RESET_PORT_MODE_THREE = 8'h00;
	localparam logic [3:0] RESET_CLOCK_STOP_LOW = 4'hf;
	localparam logic [7:0] CLOCK_STOP_HIGH_READ = 8'hf0;
	localparam logic [7:0] INHIBIT_READ_ONES = 8'haa;
	localparam logic [1:0] RESET_IRQ = 2'h0;

	// ----------------------------------------
	// counts
	// ----------------------------------------
	localparam int SYS_DIVIDE = 8192;
	localparam int WATCH_DIVIDE = 32;
	localparam int RESET_OSC_CYCLES = 512;
	// oscillator cycles per base clock cycle
	localparam int OSC_PER_BASE = 1;
	localparam logic [9:0] RESET_BASE_CYCLES =
		10'(RESET_OSC_CYCLES / OSC_PER_BASE);
	localparam logic [12:0] SYS_DIV_LAST = 13'(SYS_DIVIDE - 1);
	localparam logic [4:0] WATCH_DIV_LAST = 5'(WATCH_DIVIDE - 1);
	localparam logic [7:0] COUNTER_MAX = 8'hff;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		WDT_RUN = 2'b00,
		WDT_PENDING = 2'b01,
		WDT_RESETTING = 2'b10
	} wdt_phase_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdt_bus_req_t;

	typedef struct packed {
		logic watch_tick;
		logic halt_mode;
		logic subactive;
	} wdt_env_t;

	typedef struct packed {
		wdt_phase_t phase;
		logic [9:0] reset_count;
		logic [12:0] sys_div;
		logic [4:0] watch_div;
		logic [7:0] counter;
		logic counter_write_enable;
		logic register_write_enable;
		logic watchdog_enable;
		logic overflow_reset_flag;
		logic [7:0] port_mode_three;
		logic [3:0] clock_stop_low;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic irq;
		logic internal_reset;
		logic [7:0] rdata;
	} wdt_state_t;

endpackage

// *** core/wdt_top.sv ***
/*
 * Watchdog reset timer: counter, prescalers, protected control register,
 * internal reset generator, interrupt status and register port.
 * Assumes all inputs synchronous to clock; watch_tick is one cycle high
 * per watch clock edge; the chip feeds internal_reset back as a reset of
 * everything except this block's flag and interrupt status.
 */
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module wdt_top (
	input wire logic clock,
	input wire logic rst_b,
	input wire wdt_pkg::wdt_bus_req_t bus,
	input wire wdt_pkg::wdt_env_t env,
	output logic [7:0] rdata,
	output logic irq,
	output logic internal_reset
);

	wdt_pkg::wdt_state_t st;
	wdt_pkg::wdt_state_t next_st;

	logic wr_ctrl;
	logic wr_cnt;
	logic standby;
	logic halted;
	logic sys_tick;
	logic wtick;
	logic in_tick;
	logic overflow;
	logic [7:0] ctrl_read;

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// ----------------------------------------
	// decode and clock source
	// ----------------------------------------
	always_comb
	begin
		wr_ctrl = bus.wr && hit(bus.addr, wdt_pkg::ADDR_CTRL_STATUS);
		wr_cnt = bus.wr && hit(bus.addr, wdt_pkg::ADDR_COUNTER);
		// stored standby bit only bites once the watchdog is off
		standby = !st.clock_stop_low[wdt_pkg::BIT_WATCHDOG_MODULE_STANDBY]
			&& !st.watchdog_enable;
		halted = standby || env.halt_mode || (env.subactive &&
			!st.port_mode_three[wdt_pkg::BIT_WATCHDOG_CLOCK_SELECT]);
		sys_tick = (st.sys_div == wdt_pkg::SYS_DIV_LAST);
		wtick = env.watch_tick && (st.watch_div == wdt_pkg::WATCH_DIV_LAST);
		in_tick = st.port_mode_three[wdt_pkg::BIT_WATCHDOG_CLOCK_SELECT] ?
			wtick : sys_tick;
		// a blocked counter write must not hide the wrap
		overflow = in_tick && st.watchdog_enable && !halted
			&& st.counter == wdt_pkg::COUNTER_MAX
			&& !(wr_cnt && st.counter_write_enable)
			&& st.phase == wdt_pkg::WDT_RUN;
		ctrl_read = wdt_pkg::INHIBIT_READ_ONES;
		ctrl_read[wdt_pkg::BIT_COUNTER_WRITE_ENABLE] =
			st.counter_write_enable;
		ctrl_read[wdt_pkg::BIT_REGISTER_WRITE_ENABLE] =
			st.register_write_enable;
		ctrl_read[wdt_pkg::BIT_WATCHDOG_ENABLE] = st.watchdog_enable;
		ctrl_read[wdt_pkg::BIT_OVERFLOW_RESET_FLAG] = st.overflow_reset_flag;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;

		// prescalers
		if (halted)
		begin
			next_st.sys_div = st.sys_div;
		end
		else
		begin
			next_st.sys_div = st.sys_div + 13'h0001;
		end
		if (!halted && env.watch_tick)
		begin
			next_st.watch_div = st.watch_div + 5'h01;
		end

		// counter
		if (wr_cnt && st.counter_write_enable)
		begin
			next_st.counter = bus.wdata;
		end
		else if (in_tick && st.watchdog_enable && !halted)
		begin
			next_st.counter = st.counter + 8'h01;
		end

		// protected control register, old enables gate this write
		if (wr_ctrl)
		begin
			if (!bus.wdata[wdt_pkg::BIT_COUNTER_WE_INHIBIT])
			begin
				next_st.counter_write_enable =
					bus.wdata[wdt_pkg::BIT_COUNTER_WRITE_ENABLE];
			end
			if (!bus.wdata[wdt_pkg::BIT_REGWE_INHIBIT])
			begin
				next_st.register_write_enable =
					bus.wdata[wdt_pkg::BIT_REGISTER_WRITE_ENABLE];
			end
			if (st.register_write_enable
				&& !bus.wdata[wdt_pkg::BIT_ENABLE_INHIBIT])
			begin
				next_st.watchdog_enable =
					bus.wdata[wdt_pkg::BIT_WATCHDOG_ENABLE];
			end
			if (st.register_write_enable
				&& !bus.wdata[wdt_pkg::BIT_FLAG_INHIBIT]
				&& !bus.wdata[wdt_pkg::BIT_OVERFLOW_RESET_FLAG])
			begin
				next_st.overflow_reset_flag = 1'b0;
			end
		end

		// other registers
		if (bus.wr && hit(bus.addr, wdt_pkg::ADDR_PORT_MODE_THREE))
		begin
			next_st.port_mode_three = bus.wdata;
		end
		if (bus.wr && hit(bus.addr, wdt_pkg::ADDR_CLOCK_STOP_TWO))
		begin
			next_st.clock_stop_low = bus.wdata[3:0];
		end
		if (bus.wr && hit(bus.addr, wdt_pkg::ADDR_IRQ_MASK))
		begin
			next_st.irq_mask = bus.wdata[1:0];
		end
		if (bus.wr && hit(bus.addr, wdt_pkg::ADDR_IRQ_STATUS))
		begin
			next_st.irq_status = st.irq_status & ~bus.wdata[1:0];
		end

		// reset sequencer
		case (st.phase)
			wdt_pkg::WDT_RUN:
			begin
				if (overflow)
				begin
					next_st.phase = wdt_pkg::WDT_PENDING;
					next_st.counter = wdt_pkg::RESET_COUNTER;
				end
			end
			wdt_pkg::WDT_PENDING:
			begin
				next_st.phase = wdt_pkg::WDT_RESETTING;
				next_st.reset_count = wdt_pkg::RESET_BASE_CYCLES;
			end
			wdt_pkg::WDT_RESETTING:
			begin
				next_st.reset_count = st.reset_count - 10'h001;
				if (st.reset_count == 10'h001)
				begin
					next_st.phase = wdt_pkg::WDT_RUN;
					next_st.irq_status[wdt_pkg::BIT_IRQ_RESET_DONE] = 1'b1;
				end
			end
			default:
			begin
				next_st.phase = wdt_pkg::WDT_RUN;
			end
		endcase

		// chip reset: everything except the flag and interrupt status
		if (next_st.phase == wdt_pkg::WDT_RESETTING)
		begin
			next_st.sys_div = 13'h0000;
			next_st.watch_div = 5'h00;
			next_st.counter = wdt_pkg::RESET_COUNTER;
			next_st.counter_write_enable = 1'b0;
			next_st.register_write_enable = 1'b0;
			next_st.watchdog_enable = 1'b0;
			next_st.port_mode_three = wdt_pkg::RESET_PORT_MODE_THREE;
			next_st.clock_stop_low = wdt_pkg::RESET_CLOCK_STOP_LOW;
			next_st.irq_mask = wdt_pkg::RESET_IRQ;
		end

		// hardware set wins over a same-cycle clear
		if (st.phase == wdt_pkg::WDT_PENDING)
		begin
			next_st.overflow_reset_flag = 1'b1;
			next_st.irq_status[wdt_pkg::BIT_IRQ_OVERFLOW] = 1'b1;
		end

		next_st.internal_reset =
			(next_st.phase == wdt_pkg::WDT_RESETTING);
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);

		// read data, one cycle after the strobe
		next_st.rdata = 8'h00;
		if (bus.rd)
		begin
			case (bus.addr)
				wdt_pkg::ADDR_CTRL_STATUS: next_st.rdata = ctrl_read;
				wdt_pkg::ADDR_COUNTER: next_st.rdata = st.counter;
				wdt_pkg::ADDR_IRQ_STATUS: next_st.rdata = {6'h00, st.irq_status};
				wdt_pkg::ADDR_IRQ_MASK: next_st.rdata = {6'h00, st.irq_mask};
				wdt_pkg::ADDR_PORT_MODE_THREE: next_st.rdata = st.port_mode_three;
				wdt_pkg::ADDR_CLOCK_STOP_TWO:
					next_st.rdata = wdt_pkg::CLOCK_STOP_HIGH_READ
						| {4'h0, st.clock_stop_low};
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st.phase <= wdt_pkg::WDT_RUN;
			st.reset_count <= 10'h000;
			st.sys_div <= 13'h0000;
			st.watch_div <= 5'h00;
			st.counter <= wdt_pkg::RESET_COUNTER;
			st.counter_write_enable <= 1'b0;
			st.register_write_enable <= 1'b0;
			st.watchdog_enable <= 1'b0;
			st.overflow_reset_flag <= 1'b0;
			st.port_mode_three <= wdt_pkg::RESET_PORT_MODE_THREE;
			st.clock_stop_low <= wdt_pkg::RESET_CLOCK_STOP_LOW;
			st.irq_status <= wdt_pkg::RESET_IRQ;
			st.irq_mask <= wdt_pkg::RESET_IRQ;
			st.irq <= 1'b0;
			st.internal_reset <= 1'b0;
			st.rdata <= 8'h00;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign irq = st.irq;
	assign internal_reset = st.internal_reset;

endmodule

`default_nettype wire

// *** verification/wdt_props.sv ***
/* wdt_props: concurrent properties on the ports of wdt_top.
 assumes the bus follows the register port contract. */
`timescale 1ns/100ps
`default_nettype none
module wdt_props (
	input wire logic clock,
	input wire logic rst_b,
	input wire wdt_pkg::wdt_bus_req_t bus,
	input wire wdt_pkg::wdt_env_t env,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic internal_reset
);
	// --------
	// helpers
	// --------
	logic [9:0] hi_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence rd_ctrl;
		bus.rd && bus.addr == wdt_pkg::ADDR_CTRL_STATUS;
	endsequence
	sequence rd_cnt;
		bus.rd && bus.addr == wdt_pkg::ADDR_COUNTER;
	endsequence
	// length of the current internal reset pulse
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			hi_cnt <= 10'h000;
		else
			hi_cnt <= internal_reset ? hi_cnt + 10'h001 : 10'h000;
	// --------
	// properties
	// --------
	AST_INHIBIT_ONES: assert property (
		rd_ctrl |=> (rdata & 8'haa) == 8'haa)
		else $error("inhibit bits not read as one");
	AST_CKSTP_HIGH: assert property (bus.rd &&
		bus.addr == wdt_pkg::ADDR_CLOCK_STOP_TWO |=> rdata[7:4] == 4'hf)
		else $error("clock stop upper bits not one");
	AST_RST_LEN: assert property (
		$fell(internal_reset) |-> hi_cnt == 10'h200)
		else $error("internal reset length wrong");
	AST_RST_MAX: assert property (hi_cnt <= 10'h200)
		else $error("internal reset too long");
	AST_FLAG_IN_RST: assert property (
		internal_reset ##0 rd_ctrl |=> rdata == 8'hab)
		else $error("flag not set during internal reset");
	AST_CNT_IN_RST: assert property (
		internal_reset ##0 rd_cnt |=> rdata == 8'h00)
		else $error("counter not cleared by internal reset");
	AST_RST_QUIET: assert property (
		$fell(internal_reset) |-> !internal_reset [*8])
		else $error("internal reset retriggered while disabled");
	AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside read answer cycle");
endmodule
bind wdt_top wdt_props wdt_props_u (.clock(clock), .rst_b(rst_b), .bus(bus),
	.env(env), .rdata(rdata), .irq(irq), .internal_reset(internal_reset));
`default_nettype wire

// *** verification/wdt_top_test.sv ***
/* wdt_top_test: self-checking bench of the watchdog reset timer.
 assumes wdt_props is bound to the design. */
`timescale 1ns/100ps
`default_nettype none
module wdt_top_test;
	localparam logic [15:0] CS = wdt_pkg::ADDR_CTRL_STATUS;
	localparam logic [15:0] CT = wdt_pkg::ADDR_COUNTER;
	localparam logic [15:0] PM = wdt_pkg::ADDR_PORT_MODE_THREE;
	localparam logic [15:0] CK = wdt_pkg::ADDR_CLOCK_STOP_TWO;
	localparam logic [15:0] IS = wdt_pkg::ADDR_IRQ_STATUS;
	localparam logic [15:0] IM = wdt_pkg::ADDR_IRQ_MASK;
	logic clock;
	logic rst_b;
	wdt_pkg::wdt_bus_req_t bus;
	wdt_pkg::wdt_env_t env;
	logic [7:0] rdata;
	logic irq;
	logic internal_reset;
	logic [7:0] exp_q[$];
	logic rd_q;
	logic tick_on;
	logic [7:0] v;
	int mismatches;
	int comparisons;
	int cycles;
	int ticks;
	int mark;
	wdt_top dut_u (.clock(clock), .rst_b(rst_b), .bus(bus), .env(env),
		.rdata(rdata), .irq(irq), .internal_reset(internal_reset));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task results;
		$display("compares %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one strobe cycle, then one idle cycle
	task acc(input logic [15:0] a, input logic [7:0] d, input logic w);
		bus <= '{a, d, w, ~w};
		@(posedge clock);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		acc(a, d, 1'b1);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(a, 8'h00, 1'b0);
	endtask
	// --------
	// monitor, ticker, timeout
	// --------
	always @(posedge clock)
	begin
		if (rd_q)
			chk(rdata, exp_q.pop_front());
		rd_q <= bus.rd;
		if (env.watch_tick)
			ticks++;
		env.watch_tick <= tick_on & ~env.watch_tick;
		cycles++;
		if (cycles == 12000)
		begin
			mismatches++;
			results();
		end
	end
	// --------
	// tests
	// --------
	initial
	begin
		bus = '0;
		env = '0;
		tick_on = 1'b0;
		rd_q = 1'b0;
		rst_b = 1'b0;
		void'($urandom(32'h32ee));
		v = 8'($urandom()) | 8'h01;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rd(CS, 8'haa);
		rd(CT, 8'h00);
		rd(PM, 8'h00);
		rd(CK, 8'hff);
		rd(16'h1234, 8'h00);
		$display("test reset values done");
		wr(CS, 8'hff);
		rd(CS, 8'haa);
		wr(CT, v);
		rd(CT, 8'h00);
		wr(CS, 8'h14);
		rd(CS, 8'hba);
		wr(CS, 8'h50);
		rd(CS, 8'hfa);
		wr(CT, v);
		rd(CT, v);
		$display("test protection done");
		wr(PM, 8'h20);
		rd(PM, 8'h20);
		wr(CT, 8'hfd);
		tick_on <= 1'b1;
		repeat (80) @(posedge clock);
		rd(CT, 8'hfd);
		ticks = 0;
		wr(CS, 8'h54);
		rd(CS, 8'hfe);
		wr(CK, 8'h00);
		rd(CK, 8'hf0);
		while (!internal_reset && cycles < 5000)
			@(negedge clock);
		tick_on <= 1'b0;
		@(posedge clock);
		chk(8'(ticks > 64 && ticks < 99), 8'h01);
		rd(CS, 8'hab);
		rd(CT, 8'h00);
		while (internal_reset)
			@(negedge clock);
		@(posedge clock);
		$display("test overflow done");
		wr(IM, 8'h01);
		@(negedge clock);
		chk(8'(irq), 8'h01);
		@(posedge clock);
		rd(IS, 8'h03);
		wr(IS, 8'h01);
		rd(IS, 8'h02);
		chk(8'(irq), 8'h00);
		wr(CS, 8'h01);
		rd(CS, 8'hab);
		wr(CS, 8'h12);
		wr(CS, 8'h12);
		rd(CS, 8'hbb);
		wr(CS, 8'h10);
		rd(CS, 8'hba);
		$display("test flag and interrupt done");
		wr(PM, 8'h20);
		wr(CS, 8'h54);
		env.halt_mode <= 1'b1;
		wr(CT, 8'hfe);
		tick_on <= 1'b1;
		repeat (200) @(posedge clock);
		rd(CT, 8'hfe);
		env.halt_mode <= 1'b0;
		env.subactive <= 1'b1;
		while (!internal_reset && cycles < 9000)
			@(negedge clock);
		tick_on <= 1'b0;
		@(posedge clock);
		chk(8'(internal_reset), 8'h01);
		rd(CS, 8'hab);
		while (internal_reset)
			@(negedge clock);
		@(posedge clock);
		env.subactive <= 1'b0;
		$display("test halt and subactive done");
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		mark = cycles;
		rd(CS, 8'haa);
		rd(IS, 8'h00);
		wr(CS, 8'h50);
		wr(CT, 8'hff);
		wr(CS, 8'h54);
		while (!internal_reset && cycles < mark + 8300)
			@(negedge clock);
		@(posedge clock);
		chk(8'(cycles - mark > 8185 && cycles - mark < 8200), 8'h01);
		while (internal_reset)
			@(negedge clock);
		@(posedge clock);
		$display("test system clock source done");
		repeat (3) @(posedge clock);
		results();
	end
endmodule
`default_nettype wire
